// File: rtl/ase_defs.vh
// Constants for the asynchronous-exit synthetic state loader
`ifndef ASE_DEFS_VH
`define ASE_DEFS_VH

// Synthetic general-register values
`define ASE_LEAF_RESUME     64'h0000_0000_0000_0003
`define ASE_GP_ZERO         64'h0000_0000_0000_0000
`define ASE_LOW32_MASK      64'h0000_0000_FFFF_FFFF

// Flags cleared: carry 0, parity 2, aux carry 4, zero 6, sign 7, overflow 11, resume 16
`define ASE_FLAGS_CLR       64'h0000_0000_0001_08D5

// Exit cause vectors
`define ASE_VEC_PAGE_FAULT  8'h0E
`define ASE_VEC_FP_MATH     8'h10
`define ASE_VEC_SIMD_FP     8'h13

// x87 and media synthetic words
`define ASE_FPCTL_MATH      16'h037E
`define ASE_FPCTL_OTHER     16'h037F
`define ASE_FPSTAT_MATH     16'h8081
`define ASE_FPSTAT_OTHER    16'h0000
`define ASE_MEDIA_SIMD      32'h0000_1F01
`define ASE_MEDIA_OTHER     32'h0000_1FB0

// Fault address: low 12 bits cleared
`define ASE_FA_PAGE_MASK    64'hFFFF_FFFF_FFFF_F000

// Feature bits 1:0 are x87 and vector media, handled separately
`define ASE_XF_LEGACY       64'h0000_0000_0000_0003

// Misc select bit 0 never gets synthetic state
`define ASE_MISC_KEEP       32'h0000_0001

`endif

// File: rtl/ase_cause_decode.v
// Cause-dependent synthetic x87, media and fault-address values
`timescale 1ns/1ps
`include "ase_defs.vh"

module ase_cause_decode (
  // Exit cause
  input  wire [7:0]  exiting_event,
  input  wire        page_fault_vmexit,
  input  wire        page_fault_nested,
  input  wire [63:0] fault_addr_in,
  // Synthetic values
  output reg  [15:0] fp_control_word,
  output reg  [15:0] fp_status_word,
  output reg  [31:0] media_ctrl_status,
  output reg         fault_addr_we,
  output reg  [63:0] fault_addr_val
);

  always @* begin
    if (exiting_event == `ASE_VEC_FP_MATH) begin
      fp_control_word = `ASE_FPCTL_MATH;  // [RQ9]
      fp_status_word  = `ASE_FPSTAT_MATH; // [RQ10]
    end else begin
      fp_control_word = `ASE_FPCTL_OTHER;  // [RQ9]
      fp_status_word  = `ASE_FPSTAT_OTHER; // [RQ10]
    end
    if (exiting_event == `ASE_VEC_SIMD_FP)
      media_ctrl_status = `ASE_MEDIA_SIMD;  // [RQ11]
    else
      media_ctrl_status = `ASE_MEDIA_OTHER; // [RQ11]
    // A nested fault during delivery is not the cause; a direct VM exit leaves it alone
    fault_addr_we  = (exiting_event == `ASE_VEC_PAGE_FAULT) && !page_fault_vmexit
                     && !page_fault_nested; // [RQ12] [RQ13] [RQ14]
    fault_addr_val = fault_addr_in & `ASE_FA_PAGE_MASK; // [RQ12]
  end

endmodule

// File: rtl/ase_synth_state.v
// Synthetic architectural state loader for asynchronous enclave exits
//
// Behaviour
// (RQ1) Accumulator loads 3, the resume-enclave leaf index.
// (RQ2) Base register loads the interrupted thread's control structure pointer.
// (RQ3) Count register and instruction pointer both load the async exit pointer.
// (RQ4) Data register and both string-index registers load zero.
// (RQ5) Extended registers zeroed in 64-bit mode, untouched in 32-bit mode.
// (RQ6) Values are low 32 bits in 32-bit mode, full 64 otherwise.
// (RQ7) Clear carry, parity, aux-carry, zero, sign, overflow, resume flags; keep others.
// (RQ8) x87 and vector media state return to initial state otherwise.
// (RQ9) Control word 037E on math fault, else 037F.
// (RQ10) Status word 8081 on math fault, else 0.
// (RQ11) Media control/status 1F01 on SIMD fault, else 1FB0.
// (RQ12) Causing page fault without direct VM exit clears fault address low 12 bits.
// (RQ13) Page fault directly causing VM exit leaves fault address untouched.
// (RQ14) Page fault during delivery of another event leaves low bits alone.
// (RQ15) Thread segment registers restored to values at last entry or resume.
// (RQ16) With extended save enabled, reset requested features in bits 63:2.
// (RQ17) In 32-bit mode features absent from 32-bit mode stay unchanged.
// (RQ18) Misc state overridden only after saving, never misc select bit 0.
// (RQ19) Stack and frame pointers restored to pre-entry values.
// (RQ20) Save state to frame first, then load, then advance slot index; slot_advance pulses in the same cycle as state_load.
// (RQ21) All synthetic values loaded before handing over to dispatch.
`timescale 1ns/1ps
`include "ase_defs.vh"

module ase_synth_state #(
  parameter SEG_W  = 128,
  parameter SLOT_W = 32
) (
  // Clock and reset
  input  wire              sys_clk,
  input  wire              rst,
  // Exit request from event dispatch
  input  wire              async_enclave_exit,
  input  wire [7:0]        exiting_event,
  input  wire              page_fault_vmexit,
  input  wire              page_fault_nested,
  input  wire              mode64,
  // Thread and enclave context
  input  wire [63:0]       thread_control_struct,
  input  wire [63:0]       async_exit_pointer,
  input  wire [63:0]       saved_outer_stack_ptr,
  input  wire [63:0]       saved_outer_frame_ptr,
  input  wire [SEG_W-1:0]  saved_seg0,
  input  wire [SEG_W-1:0]  saved_seg1,
  input  wire [SLOT_W-1:0] current_save_slot,
  // Live architectural inputs
  input  wire [63:0]       flags_in,
  input  wire [63:0]       fault_addr_in,
  // Extended feature and misc controls
  input  wire              ext_save_enable,
  input  wire [63:0]       feature_enable_ctrl,
  input  wire [63:0]       enclave_feature_mask,
  input  wire [63:0]       mode32_feature_mask,
  input  wire [31:0]       misc_state_select,
  input  wire [31:0]       misc_synth_mask,
  // Save-area handshake
  output reg               save_req,
  input  wire              save_done,
  // Register load strobe and values
  output reg               state_load,
  output reg               gp_wide,
  output reg  [63:0]       accumulator_reg,
  output reg  [63:0]       base_gp_reg,
  output reg  [63:0]       count_reg,
  output reg  [63:0]       data_gp_reg,
  output reg  [63:0]       src_index_reg,
  output reg  [63:0]       dst_index_reg,
  output reg  [63:0]       stack_ptr_reg,
  output reg  [63:0]       frame_ptr_reg,
  output reg               extended_gp_zero,
  output reg  [63:0]       instr_ptr_reg,
  output reg  [63:0]       flags_reg,
  output reg               fp_media_init,
  output reg  [15:0]       fp_control_word,
  output reg  [15:0]       fp_status_word,
  output reg  [31:0]       media_ctrl_status,
  output reg               fault_addr_we,
  output reg  [63:0]       fault_addr_reg,
  output reg  [SEG_W-1:0]  seg0_reg,
  output reg  [SEG_W-1:0]  seg1_reg,
  output reg  [63:0]       ext_init_mask,
  output reg  [31:0]       misc_override_mask,
  // Slot advance and completion
  output reg               slot_advance,
  output reg  [SLOT_W-1:0] next_save_slot,
  output reg               exit_done,
  output reg               busy
);

  localparam ST_IDLE = 2'b00;
  localparam ST_SAVE = 2'b01;
  localparam ST_LOAD = 2'b10;
  localparam ST_DONE = 2'b11;

  reg  [1:0]  state;
  reg  [7:0]  cause;
  reg         cause_vmexit;
  reg         cause_nested;
  reg         cap_mode64;

  wire [15:0] dec_fp_ctl;
  wire [15:0] dec_fp_stat;
  wire [31:0] dec_media;
  wire        dec_fa_we;
  wire [63:0] dec_fa;

  // Narrows a synthetic value to the active register width
  function [63:0] fit_width;
    input        wide;
    input [63:0] value;
    begin
      fit_width = wide ? value : (value & `ASE_LOW32_MASK); // [RQ6]
    end
  endfunction

  ase_cause_decode u_decode (
    .exiting_event      (cause),
    .page_fault_vmexit  (cause_vmexit),
    .page_fault_nested  (cause_nested),
    .fault_addr_in      (fault_addr_in),
    .fp_control_word    (dec_fp_ctl),
    .fp_status_word     (dec_fp_stat),
    .media_ctrl_status  (dec_media),
    .fault_addr_we      (dec_fa_we),
    .fault_addr_val     (dec_fa)
  );

  // Cause is captured at the request so the decode stays stable while saving
  always @(posedge sys_clk) begin
    if (rst) begin
      state              <= ST_IDLE;
      cause              <= 8'h00;
      cause_vmexit       <= 1'b0;
      cause_nested       <= 1'b0;
      cap_mode64         <= 1'b0;
      save_req           <= 1'b0;
      state_load         <= 1'b0;
      gp_wide            <= 1'b0;
      accumulator_reg    <= `ASE_GP_ZERO;
      base_gp_reg        <= `ASE_GP_ZERO;
      count_reg          <= `ASE_GP_ZERO;
      data_gp_reg        <= `ASE_GP_ZERO;
      src_index_reg      <= `ASE_GP_ZERO;
      dst_index_reg      <= `ASE_GP_ZERO;
      stack_ptr_reg      <= `ASE_GP_ZERO;
      frame_ptr_reg      <= `ASE_GP_ZERO;
      extended_gp_zero   <= 1'b0;
      instr_ptr_reg      <= `ASE_GP_ZERO;
      flags_reg          <= `ASE_GP_ZERO;
      fp_media_init      <= 1'b0;
      fp_control_word    <= `ASE_FPCTL_OTHER;
      fp_status_word     <= `ASE_FPSTAT_OTHER;
      media_ctrl_status  <= `ASE_MEDIA_OTHER;
      fault_addr_we      <= 1'b0;
      fault_addr_reg     <= `ASE_GP_ZERO;
      seg0_reg           <= {SEG_W{1'b0}};
      seg1_reg           <= {SEG_W{1'b0}};
      ext_init_mask      <= 64'h0000_0000_0000_0000;
      misc_override_mask <= 32'h0000_0000;
      slot_advance       <= 1'b0;
      next_save_slot     <= {SLOT_W{1'b0}};
      exit_done          <= 1'b0;
      busy               <= 1'b0;
    end else begin
      state_load         <= 1'b0;
      extended_gp_zero   <= 1'b0;
      fp_media_init      <= 1'b0;
      fault_addr_we      <= 1'b0;
      slot_advance       <= 1'b0;
      exit_done          <= 1'b0;
      misc_override_mask <= 32'h0000_0000;
      ext_init_mask      <= 64'h0000_0000_0000_0000;
      case (state)
        ST_IDLE: begin
          if (async_enclave_exit) begin
            cause           <= exiting_event;
            cause_vmexit    <= page_fault_vmexit;
            cause_nested    <= page_fault_nested;
            cap_mode64      <= mode64;
            save_req        <= 1'b1; // [RQ20]
            busy            <= 1'b1;
            state           <= ST_SAVE;
          end
        end
        ST_SAVE: begin
          // Nothing synthetic is driven until the frame holds the real state
          if (save_done) begin
            save_req <= 1'b0;
            state    <= ST_LOAD; // [RQ20]
          end
        end
        ST_LOAD: begin
          state_load        <= 1'b1;
          gp_wide           <= cap_mode64; // [RQ6]
          accumulator_reg   <= `ASE_LEAF_RESUME; // [RQ1]
          base_gp_reg       <= fit_width(cap_mode64, thread_control_struct); // [RQ2]
          count_reg         <= fit_width(cap_mode64, async_exit_pointer); // [RQ3]
          instr_ptr_reg     <= fit_width(cap_mode64, async_exit_pointer); // [RQ3]
          data_gp_reg       <= `ASE_GP_ZERO; // [RQ4]
          src_index_reg     <= `ASE_GP_ZERO; // [RQ4]
          dst_index_reg     <= `ASE_GP_ZERO; // [RQ4]
          extended_gp_zero  <= cap_mode64; // [RQ5]
          stack_ptr_reg     <= fit_width(cap_mode64, saved_outer_stack_ptr); // [RQ19]
          frame_ptr_reg     <= fit_width(cap_mode64, saved_outer_frame_ptr); // [RQ19]
          flags_reg         <= fit_width(cap_mode64, flags_in & ~`ASE_FLAGS_CLR); // [RQ7]
          fp_media_init     <= 1'b1; // [RQ8]
          fp_control_word   <= dec_fp_ctl; // [RQ9]
          fp_status_word    <= dec_fp_stat; // [RQ10]
          media_ctrl_status <= dec_media; // [RQ11]
          fault_addr_we     <= dec_fa_we; // [RQ12] [RQ13] [RQ14]
          fault_addr_reg    <= dec_fa; // [RQ12]
          seg0_reg          <= saved_seg0; // [RQ15]
          seg1_reg          <= saved_seg1; // [RQ15]
          if (ext_save_enable)
            ext_init_mask <= enclave_feature_mask & feature_enable_ctrl & ~`ASE_XF_LEGACY
                             & (cap_mode64 ? ~64'h0000_0000_0000_0000
                                           : mode32_feature_mask); // [RQ16] [RQ17]
          misc_override_mask <= misc_state_select & misc_synth_mask & ~`ASE_MISC_KEEP; // [RQ18]
          slot_advance       <= 1'b1; // [RQ20]
          next_save_slot     <= current_save_slot + {{(SLOT_W-1){1'b0}}, 1'b1}; // [RQ20]
          state              <= ST_DONE;
        end
        ST_DONE: begin
          // Dispatch resumes only after the load cycle has been presented
          exit_done <= 1'b1; // [RQ21]
          busy      <= 1'b0;
          state     <= ST_IDLE;
        end
        default: begin
          save_req <= 1'b0;
          busy     <= 1'b0;
          state    <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// File: tb/ase_synth_state_monitor.sv
// Concurrent checks on the synthetic state loader outputs
`timescale 1ns/1ps
module ase_synth_state_monitor (
  // Clock and reset
  input wire        sys_clk,
  input wire        rst,
  // Strobes
  input wire        state_load,
  input wire        gp_wide,
  input wire        extended_gp_zero,
  input wire        exit_done,
  input wire        busy,
  input wire        save_req,
  input wire        fp_media_init,
  // Values
  input wire [63:0] accumulator_reg,
  input wire [63:0] count_reg,
  input wire [63:0] instr_ptr_reg,
  input wire [63:0] data_gp_reg,
  input wire [63:0] src_index_reg,
  input wire [63:0] dst_index_reg,
  input wire [63:0] flags_reg,
  input wire [15:0] fp_control_word,
  input wire [15:0] fp_status_word,
  input wire [31:0] media_ctrl_status,
  input wire [31:0] misc_override_mask
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_acc_leaf: assert property (state_load |-> accumulator_reg == 64'h3) else $error("bad accumulator");
  a_count_ip: assert property (state_load |-> count_reg == instr_ptr_reg) else $error("count and ip differ");
  a_zero_idx: assert property (state_load |-> (data_gp_reg | src_index_reg | dst_index_reg) == 64'h0)
    else $error("data or index not zero");
  a_ext_mode: assert property (state_load |-> extended_gp_zero == gp_wide) else $error("ext zero vs mode");
  a_narrow_upper: assert property (state_load && !gp_wide |-> count_reg[63:32] == 32'h0)
    else $error("upper half not zero");
  a_flags_clr: assert property (state_load |-> (flags_reg & 64'h108D5) == 64'h0) else $error("flags not cleared");
  a_init_pulse: assert property (fp_media_init == state_load) else $error("init strobe off load");
  a_fp_pair: assert property (state_load |-> fp_control_word == (fp_status_word == 16'h8081 ? 16'h037E : 16'h037F))
    else $error("control and status words disagree");
  a_mx_legal: assert property (state_load |-> media_ctrl_status == 32'h1F01 || media_ctrl_status == 32'h1FB0)
    else $error("bad media word");
  a_misc_keep: assert property (misc_override_mask[0] == 1'b0) else $error("misc bit 0 overridden");
  a_save_first: assert property (save_req |-> !state_load) else $error("load during save");
  a_done_follow: assert property (state_load |=> exit_done && !busy && !state_load)
    else $error("no completion after load");
endmodule

// File: tb/ase_dispatch_model.sv
// Event dispatch side: answers save requests after a set delay
`timescale 1ns/1ps
module ase_dispatch_model (
  // Clock and reset
  input  wire       sys_clk,
  input  wire       rst,
  // Save handshake
  input  wire       save_req,
  input  wire [7:0] delay,
  output reg        save_done
);
  reg [7:0] cnt;
  // One pulse per request, so a slow frame write is never seen twice
  always @(negedge sys_clk) begin
    if (rst || !save_req) begin
      cnt       <= 8'h00;
      save_done <= 1'b0;
    end else begin
      save_done <= (cnt == delay);
      cnt       <= cnt + 8'h01;
    end
  end
endmodule

// File: tb/ase_synth_state_tb.sv
// Testbench for the asynchronous-exit synthetic state loader
`timescale 1ns/1ps
module ase_synth_state_tb;
  reg          sys_clk, rst, async_enclave_exit, page_fault_vmexit, page_fault_nested, mode64, ext_save_enable;
  reg  [7:0]   exiting_event, dly;
  reg  [63:0]  thread_control_struct, async_exit_pointer, saved_outer_stack_ptr, saved_outer_frame_ptr;
  reg  [63:0]  flags_in, fault_addr_in, feature_enable_ctrl, enclave_feature_mask, mode32_feature_mask;
  reg  [127:0] saved_seg0, saved_seg1;
  reg  [31:0]  current_save_slot, misc_state_select, misc_synth_mask;
  wire         save_req, save_done, state_load, gp_wide, extended_gp_zero, fp_media_init, fault_addr_we;
  wire         slot_advance, exit_done, busy;
  wire [63:0]  accumulator_reg, base_gp_reg, count_reg, data_gp_reg, src_index_reg, dst_index_reg, stack_ptr_reg;
  wire [63:0]  frame_ptr_reg, instr_ptr_reg, flags_reg, fault_addr_reg, ext_init_mask;
  wire [15:0]  fp_control_word, fp_status_word;
  wire [31:0]  media_ctrl_status, misc_override_mask, next_save_slot;
  wire [127:0] seg0_reg, seg1_reg;
  integer      failures, cmp_count, i, n;

  ase_synth_state u_dut (.sys_clk, .rst, .async_enclave_exit, .exiting_event, .page_fault_vmexit, .page_fault_nested,
    .mode64, .thread_control_struct, .async_exit_pointer, .saved_outer_stack_ptr, .saved_outer_frame_ptr, .saved_seg0,
    .saved_seg1, .current_save_slot, .flags_in, .fault_addr_in, .ext_save_enable, .feature_enable_ctrl,
    .enclave_feature_mask, .mode32_feature_mask, .misc_state_select, .misc_synth_mask, .save_req, .save_done,
    .state_load, .gp_wide, .accumulator_reg, .base_gp_reg, .count_reg, .data_gp_reg, .src_index_reg, .dst_index_reg,
    .stack_ptr_reg, .frame_ptr_reg, .extended_gp_zero, .instr_ptr_reg, .flags_reg, .fp_media_init, .fp_control_word,
    .fp_status_word, .media_ctrl_status, .fault_addr_we, .fault_addr_reg, .seg0_reg, .seg1_reg, .ext_init_mask,
    .misc_override_mask, .slot_advance, .next_save_slot, .exit_done, .busy);
  ase_dispatch_model u_far (.sys_clk, .rst, .save_req, .delay(dly), .save_done);

  task chk(input [255:0] nm, input [127:0] s, input [127:0] e);
    begin
      cmp_count = cmp_count + 1;
      if (s !== e) begin
        failures = failures + 1;
        $display("ERROR %0s expected %h seen %h", nm, e, s);
      end
    end
  endtask

  function [63:0] fit(input [63:0] v);
    fit = mode64 ? v : v & 64'h0000_0000_FFFF_FFFF;
  endfunction

  task finish_test;
    begin
      $display("Comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask

  // Request held two cycles: the second is refused while busy
  task run(input [7:0] v, input dv, input dl, input m, input es, input [7:0] d);
    begin
      @(negedge sys_clk);
      {exiting_event, page_fault_vmexit, page_fault_nested, mode64, ext_save_enable, dly} = {v, dv, dl, m, es, d};
      async_enclave_exit = 1'b1;
      @(negedge sys_clk);
      @(negedge sys_clk);
      async_enclave_exit = 1'b0;
      n = 0;
      for (i = 0; i < 30; i = i + 1) begin
        @(negedge sys_clk);
        if (state_load === 1'b1) begin
          n = n + 1;
          chk("acc", accumulator_reg, 128'h3);
          chk("base", base_gp_reg, fit(thread_control_struct));
          chk("count", count_reg, fit(async_exit_pointer));
          chk("ip", instr_ptr_reg, fit(async_exit_pointer));
          chk("zeros", data_gp_reg | src_index_reg | dst_index_reg, 128'h0);
          chk("xzero", extended_gp_zero, m);
          chk("wide", gp_wide, m);
          chk("flags", flags_reg, fit(flags_in & ~64'h108D5));
          chk("init", fp_media_init, 128'h1);
          chk("fpctl", fp_control_word, v == 8'h10 ? 16'h037E : 16'h037F);
          chk("fpstat", fp_status_word, v == 8'h10 ? 16'h8081 : 16'h0000);
          chk("media", media_ctrl_status, v == 8'h13 ? 32'h1F01 : 32'h1FB0);
          chk("fawe", fault_addr_we, v == 8'h0E && !dv && !dl);
          if (fault_addr_we === 1'b1) chk("fa", fault_addr_reg, fault_addr_in & ~64'hFFF);
          chk("seg0", seg0_reg, saved_seg0);
          chk("seg1", seg1_reg, saved_seg1);
          chk("xinit", ext_init_mask, es ? enclave_feature_mask & feature_enable_ctrl & ~64'h3 &
            (m ? ~64'h0 : mode32_feature_mask) : 64'h0);
          chk("misc", misc_override_mask, misc_state_select & misc_synth_mask & ~32'h1);
          chk("sp", stack_ptr_reg, fit(saved_outer_stack_ptr));
          chk("fp", frame_ptr_reg, fit(saved_outer_frame_ptr));
          chk("slot", {slot_advance, next_save_slot}, {1'b1, current_save_slot + 32'h1});
        end
      end
      chk("loads", n, 128'h1);
      chk("idle", busy, 128'h0);
    end
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  initial begin
    failures = 0;
    cmp_count = 0;
    rst = 1'b1;
    async_enclave_exit = 1'b0;
    {exiting_event, page_fault_vmexit, page_fault_nested, mode64, ext_save_enable, dly} = 20'h0;
    {thread_control_struct, async_exit_pointer} = {64'hA5A5_1234_0000_7000, 64'h9876_5432_1000_0040};
    {saved_outer_stack_ptr, saved_outer_frame_ptr} = {64'hFEDC_0000_0012_3450, 64'h0BAD_0000_0012_3480};
    {flags_in, fault_addr_in} = {64'hFFFF_FFFF_FFFF_FFFF, 64'h7FFF_1234_5678_9ABC};
    {feature_enable_ctrl, enclave_feature_mask, mode32_feature_mask} = {64'hFF, 64'hE7, 64'h0F};
    saved_seg0 = 128'h1111_2222_3333_4444_5555_6666_7777_8888;
    saved_seg1 = 128'hC3C3_0F0F_ABCD_0123_4567_89AB_CDEF_0001;
    {current_save_slot, misc_state_select, misc_synth_mask} = {32'h0000_0002, 32'h0000_0007, 32'h0000_0005};
    // Count rising edges: a clock settling at time zero must not shorten reset
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    chk("rfcw", fp_control_word, 16'h037F);
    chk("rmx", media_ctrl_status, 32'h1FB0);
    run(8'h0E, 1'b0, 1'b0, 1'b1, 1'b1, 8'h00);
    run(8'h0E, 1'b1, 1'b0, 1'b1, 1'b1, 8'h03);
    run(8'h0E, 1'b0, 1'b1, 1'b0, 1'b1, 8'h01);
    run(8'h10, 1'b0, 1'b0, 1'b0, 1'b0, 8'h02);
    // Reset after a math fault must bring the fault words back to idle values
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    chk("rfpctl", fp_control_word, 16'h037F);
    chk("rfpstat", fp_status_word, 16'h0000);
    chk("rbusy", busy, 128'h0);
    run(8'h13, 1'b0, 1'b0, 1'b1, 1'b1, 8'h00);
    run(8'h20, 1'b0, 1'b0, 1'b0, 1'b1, 8'h05);
    finish_test;
  end

  // Six exits of about 33 cycles each plus two resets finish well inside this span
  initial begin
    #2000;
    failures = failures + 1;
    finish_test;
  end
endmodule

bind ase_synth_state ase_synth_state_monitor u_mon (.sys_clk, .rst, .state_load, .gp_wide, .extended_gp_zero,
  .exit_done, .busy, .save_req, .fp_media_init, .accumulator_reg, .count_reg, .instr_ptr_reg, .data_gp_reg,
  .src_index_reg, .dst_index_reg, .flags_reg, .fp_control_word, .fp_status_word, .media_ctrl_status,
  .misc_override_mask);
